// File: logic/shreg_pkg.sv
// Shared constants, register map and types for the universal shift/storage register.
// Assumes a single 40 MHz clock domain and an AXI4-Lite register master.
package shreg_pkg;
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int AXI_ADDR_W = 8;

  localparam logic [AXI_ADDR_W-1:0] CTRL_OFFSET    = 8'h00;
  localparam logic [AXI_ADDR_W-1:0] STATUS_OFFSET  = 8'h04;
  localparam logic [AXI_ADDR_W-1:0] CAPTURE_OFFSET = 8'h08;

  localparam int CAPTURE_EN_BIT = 0;
  localparam int OVERFLOW_BIT   = 18;

  localparam logic [DATA_W-1:0] STATE_RESET      = 8'h00;
  localparam logic              CAPTURE_EN_RESET = 1'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    MODE_HOLD  = 4'b0001,
    MODE_SHR   = 4'b0010,
    MODE_SHL   = 4'b0100,
    MODE_LOAD  = 4'b1000
  } mode_t;

  typedef struct packed {
    logic [12:0]       rsvd;
    logic              overflow;
    logic              full;
    logic              empty;
    logic [7:0]        fill;
    logic [DATA_W-1:0] state;
  } status_t;

  typedef struct packed {
    logic [22:0]       rsvd;
    logic              valid;
    logic [DATA_W-1:0] data;
  } capture_t;
endpackage

// File: logic/universal_shift_storage_register.sv
// Eight-bit universal shift/storage register with shared parallel pins,
// a capture FIFO of register snapshots and an AXI4-Lite register slave.
// Assumes the pin-side logic runs on i_clk, so pins are sampled directly.
// Overview of operation
// - Eight state bits change only on rising edges
// - Low clear overrides selects, zeroes all bits
// - Both selects high: load bits from pins
// - Select low-only high: shift up, serial into bit0
// - Select high-only high: shift down, serial into bit7
// - Pins driven only when both enables low
// - Operations continue while pin drivers disabled
// - Pin drivers released during parallel load mode
// - Bit zero and seven always on serial outputs
`timescale 1ns/1ps

module capture_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_in_valid,
  output logic                          o_in_ready,
  input  wire logic [WIDTH-1:0]         i_in_data,
  output logic                          o_out_valid,
  input  wire logic                     i_out_ready,
  output logic [WIDTH-1:0]              o_out_data,
  output logic [$clog2(DEPTH):0]        o_level
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem      [DEPTH];
  logic [WIDTH-1:0] next_mem [DEPTH];
  logic [AW-1:0]    wr_ptr, next_wr_ptr;
  logic [AW-1:0]    rd_ptr, next_rd_ptr;
  logic [AW:0]      count,  next_count;
  logic             push, pop;

  assign o_in_ready  = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign o_level     = count;
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_comb begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_mem[wr_ptr] = i_in_data;
      next_wr_ptr      = wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Storage needs no reset; pointers and count define what is valid
  always_ff @(posedge i_clk) begin
    mem <= next_mem;
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end
endmodule

module universal_shift_storage_register
  import shreg_pkg::*;
(
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic                  i_right_shift_serial_in,
  input  wire logic                  i_left_shift_serial_in,
  input  wire logic                  i_mode_select_low,
  input  wire logic                  i_mode_select_high,
  input  wire logic                  i_sync_clear_n,
  input  wire logic                  i_output_enable_a_n,
  input  wire logic                  i_output_enable_b_n,
  input  wire logic [DATA_W-1:0]     i_shared_parallel_pins,
  output logic      [DATA_W-1:0]     o_shared_parallel_pins,
  output logic      [DATA_W-1:0]     o_shared_parallel_pins_oe_n,
  output logic                       o_low_end_serial_out,
  output logic                       o_high_end_serial_out,
  output logic                       o_capture_ready,
  input  wire logic                  i_awvalid,
  output logic                       o_awready,
  input  wire logic [AXI_ADDR_W-1:0] i_awaddr,
  input  wire logic                  i_wvalid,
  output logic                       o_wready,
  input  wire logic [31:0]           i_wdata,
  input  wire logic [3:0]            i_wstrb,
  output logic                       o_bvalid,
  input  wire logic                  i_bready,
  output logic      [1:0]            o_bresp,
  input  wire logic                  i_arvalid,
  output logic                       o_arready,
  input  wire logic [AXI_ADDR_W-1:0] i_araddr,
  output logic                       o_rvalid,
  input  wire logic                  i_rready,
  output logic      [31:0]           o_rdata,
  output logic      [1:0]            o_rresp
);
  // One-hot select: bit0 control, bit1 status, bit2 capture
  function automatic logic [2:0] reg_sel(input logic [AXI_ADDR_W-1:0] addr);
    reg_sel = {addr == CAPTURE_OFFSET, addr == STATUS_OFFSET, addr == CTRL_OFFSET};
  endfunction

  function automatic mode_t decode_mode(input logic sel_high, input logic sel_low);
    case ({sel_high, sel_low})
      2'b01:   decode_mode = MODE_SHR;
      2'b10:   decode_mode = MODE_SHL;
      2'b11:   decode_mode = MODE_LOAD;
      default: decode_mode = MODE_HOLD;
    endcase
  endfunction

  mode_t             mode;
  logic [DATA_W-1:0] state,  next_state;
  logic [DATA_W-1:0] shr_val, shl_val;
  logic              capture_en, next_capture_en;
  logic              overflow,   next_overflow;
  logic              push_valid, push_lost;
  logic              fifo_out_valid, fifo_pop;
  logic [DATA_W-1:0] fifo_out_data;
  logic [5:0]        fifo_level;
  logic              aw_full, next_aw_full, w_full, next_w_full;
  logic [AXI_ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [31:0]       w_data, next_w_data;
  logic [3:0]        w_strb, next_w_strb;
  logic              bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0]        bresp, next_bresp, rresp, next_rresp;
  logic [31:0]       rdata, next_rdata;
  logic              do_write, ar_take, ovf_clear;
  logic [2:0]        wsel, rsel;
  status_t           status;
  capture_t          capture;

  assign mode    = decode_mode(i_mode_select_high, i_mode_select_low);
  assign shr_val = {state[DATA_W-2:0], i_right_shift_serial_in};
  assign shl_val = {i_left_shift_serial_in, state[DATA_W-1:1]};

  // Enables act on the pins only; the state path below never looks at them
  always_comb begin
    next_state = state;
    if (!i_sync_clear_n) begin
      next_state = STATE_RESET;
    end else begin
      case (mode)
        MODE_LOAD: next_state = i_shared_parallel_pins;
        MODE_SHR:  next_state = shr_val;
        MODE_SHL:  next_state = shl_val;
        MODE_HOLD: next_state = state;
        default:   next_state = state;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state <= STATE_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign o_shared_parallel_pins      = state;
  assign o_shared_parallel_pins_oe_n = {DATA_W{i_output_enable_a_n | i_output_enable_b_n | (mode == MODE_LOAD)}};
  assign o_low_end_serial_out        = state[0];
  assign o_high_end_serial_out       = state[DATA_W-1];

  // Snapshot every edge that may change the state; a full FIFO drops it and flags overflow
  assign push_valid = capture_en && (!i_sync_clear_n || mode != MODE_HOLD);
  assign push_lost  = push_valid && !o_capture_ready;

  capture_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk       (i_clk),
    .i_rst_n     (i_rst_n),
    .i_in_valid  (push_valid),
    .o_in_ready  (o_capture_ready),
    .i_in_data   (next_state),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (fifo_pop),
    .o_out_data  (fifo_out_data),
    .o_level     (fifo_level)
  );

  // AXI4-Lite slave, one write and one read outstanding
  assign o_awready = !aw_full && !bvalid;
  assign o_wready  = !w_full && !bvalid;
  assign o_arready = !rvalid;
  assign o_bvalid  = bvalid;
  assign o_bresp   = bresp;
  assign o_rvalid  = rvalid;
  assign o_rdata   = rdata;
  assign o_rresp   = rresp;
  assign do_write  = aw_full && w_full && !bvalid;
  assign ar_take   = i_arvalid && o_arready;
  assign wsel      = reg_sel(aw_addr);
  assign rsel      = reg_sel(i_araddr);
  assign fifo_pop  = ar_take && rsel[2];
  assign ovf_clear = do_write && wsel[1] && w_strb[2] && w_data[OVERFLOW_BIT];

  always_comb begin
    status          = '0;
    status.state    = state;
    status.fill     = {2'h0, fifo_level};
    status.empty    = !fifo_out_valid;
    status.full     = !o_capture_ready;
    status.overflow = overflow;
    capture         = '0;
    capture.valid   = fifo_out_valid;
    capture.data    = fifo_out_data;
  end

  always_comb begin
    next_aw_full    = aw_full;
    next_aw_addr    = aw_addr;
    next_w_full     = w_full;
    next_w_data     = w_data;
    next_w_strb     = w_strb;
    next_bvalid     = bvalid;
    next_bresp      = bresp;
    next_rvalid     = rvalid;
    next_rresp      = rresp;
    next_rdata      = rdata;
    next_capture_en = capture_en;
    // Set wins over a simultaneous software clear
    next_overflow   = push_lost || (overflow && !ovf_clear);
    if (i_awvalid && o_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      next_w_full = 1'b1;
      next_w_data = i_wdata;
      next_w_strb = i_wstrb;
    end
    if (bvalid && i_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wsel[0] || wsel[1]) ? RESP_OKAY : RESP_SLVERR;
      if (wsel[0] && w_strb[0]) begin
        next_capture_en = w_data[CAPTURE_EN_BIT];
      end
    end
    if (rvalid && i_rready) begin
      next_rvalid = 1'b0;
    end
    if (ar_take) begin
      next_rvalid = 1'b1;
      next_rresp  = (rsel != 3'h0) ? RESP_OKAY : RESP_SLVERR;
      case (rsel)
        3'b001:  next_rdata = {31'h0, capture_en};
        3'b010:  next_rdata = status;
        3'b100:  next_rdata = capture;
        default: next_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      aw_full    <= 1'b0;
      aw_addr    <= '0;
      w_full     <= 1'b0;
      w_data     <= 32'h0;
      w_strb     <= 4'h0;
      bvalid     <= 1'b0;
      bresp      <= RESP_OKAY;
      rvalid     <= 1'b0;
      rresp      <= RESP_OKAY;
      rdata      <= 32'h0;
      capture_en <= CAPTURE_EN_RESET;
      overflow   <= 1'b0;
    end else begin
      aw_full    <= next_aw_full;
      aw_addr    <= next_aw_addr;
      w_full     <= next_w_full;
      w_data     <= next_w_data;
      w_strb     <= next_w_strb;
      bvalid     <= next_bvalid;
      bresp      <= next_bresp;
      rvalid     <= next_rvalid;
      rresp      <= next_rresp;
      rdata      <= next_rdata;
      capture_en <= next_capture_en;
      overflow   <= next_overflow;
    end
  end

  sequence s_run;
    i_sync_clear_n;
  endsequence
  sequence s_shift_right;
    s_run ##0 (mode == MODE_SHR);
  endsequence
  sequence s_shift_left;
    s_run ##0 (mode == MODE_SHL);
  endsequence

  property p_clear;
    @(posedge i_clk) disable iff (!i_rst_n) !i_sync_clear_n |=> (state == STATE_RESET);
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not zero the state");

  property p_load;
    @(posedge i_clk) disable iff (!i_rst_n)
      (s_run ##0 (mode == MODE_LOAD)) |=> (state == $past(i_shared_parallel_pins));
  endproperty
  a_load: assert property (p_load) else $error("parallel load took wrong data");

  property p_shr;
    @(posedge i_clk) disable iff (!i_rst_n) s_shift_right |=> (state == $past(shr_val));
  endproperty
  a_shr: assert property (p_shr) else $error("right shift wrong");

  property p_shl;
    @(posedge i_clk) disable iff (!i_rst_n) s_shift_left |=> (state == $past(shl_val));
  endproperty
  a_shl: assert property (p_shl) else $error("left shift wrong");

  property p_hold;
    @(posedge i_clk) disable iff (!i_rst_n) (s_run ##0 (mode == MODE_HOLD)) |=> $stable(state);
  endproperty
  a_hold: assert property (p_hold) else $error("hold changed the state");

  property p_change_cause;
    @(posedge i_clk) disable iff (!i_rst_n)
      !$stable(state) |-> $past(!i_sync_clear_n || mode != MODE_HOLD);
  endproperty
  a_change_cause: assert property (p_change_cause) else $error("state changed without cause");

  property p_pins_driven;
    @(posedge i_clk) disable iff (!i_rst_n)
      (!i_output_enable_a_n && !i_output_enable_b_n && mode != MODE_LOAD)
        |-> (o_shared_parallel_pins_oe_n == '0) && (o_shared_parallel_pins == state);
  endproperty
  a_pins_driven: assert property (p_pins_driven) else $error("pins not driven");

  property p_pins_released;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_output_enable_a_n || i_output_enable_b_n || mode == MODE_LOAD) |-> (&o_shared_parallel_pins_oe_n);
  endproperty
  a_pins_released: assert property (p_pins_released) else $error("pins not released");

  property p_disabled_shift;
    @(posedge i_clk) disable iff (!i_rst_n)
      (i_output_enable_a_n ##0 s_shift_right) |=> (o_low_end_serial_out == $past(i_right_shift_serial_in));
  endproperty
  a_disabled_shift: assert property (p_disabled_shift) else $error("shift lost while disabled");

  property p_serial_out;
    @(posedge i_clk) disable iff (!i_rst_n)
      (o_low_end_serial_out == state[0]) && (o_high_end_serial_out == state[DATA_W-1]);
  endproperty
  a_serial_out: assert property (p_serial_out) else $error("serial outputs wrong");

  property p_overflow_set;
    @(posedge i_clk) disable iff (!i_rst_n) push_lost |=> overflow;
  endproperty
  a_overflow_set: assert property (p_overflow_set) else $error("lost snapshot not flagged");

  property p_write_resp;
    @(posedge i_clk) disable iff (!i_rst_n) do_write |=> bvalid ##0 !o_awready;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response missing");
endmodule

// File: testbench/shared_bus_partner.sv
// Model of the shared parallel bus and the outside logic that loads it.
// Assumes device oe_n is low on every bit that the device drives.
`timescale 1ns/1ps
module shared_bus_partner (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_dev_data,
  input  wire logic [7:0] i_dev_oe_n,
  input  wire logic       i_drive,
  input  wire logic [7:0] i_drive_data,
  output logic      [7:0] o_wire
);
  logic [7:0] last = 8'h00;
  always @(posedge i_clk) begin
    last <= o_wire;
  end
  // No pull on this bus: a floating bit shows the inverse of its last level, never a stale value
  assign o_wire = (~i_dev_oe_n & i_dev_data) | (i_dev_oe_n & (i_drive ? i_drive_data : ~last));
endmodule

// File: testbench/universal_shift_storage_register_test.sv
// Self-checking bench: random and corner shift traffic, AXI4-Lite access, capture FIFO fill and drain.
// Assumes the bus partner resolves the shared pins from all drivers.
`timescale 1ns/1ps
module universal_shift_storage_register_test;
  import shreg_pkg::*;
  logic        i_clk, i_rst_n, rsi, lsi, sel_lo, sel_hi, clr_n, oea_n, oeb_n, drive, cap_en, ovf;
  logic        aw_v, w_v, b_rdy, ar_v, r_rdy, q0, q7, cap_rdy, aw_r, w_r, b_v, ar_r, r_v;
  logic [7:0]  aw_a, ar_a, ld, dev_q, dev_oe_n, pin_wire, exp_st;
  logic [31:0] w_d, r_d, rd;
  logic [3:0]  w_s;
  logic [1:0]  b_resp, r_resp, rr;
  logic [7:0]  snaps[$];
  int          lvl, cycles, errors, checks_done;

  universal_shift_storage_register dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_right_shift_serial_in(rsi),
    .i_left_shift_serial_in(lsi), .i_mode_select_low(sel_lo), .i_mode_select_high(sel_hi),
    .i_sync_clear_n(clr_n), .i_output_enable_a_n(oea_n), .i_output_enable_b_n(oeb_n),
    .i_shared_parallel_pins(pin_wire), .o_shared_parallel_pins(dev_q), .o_shared_parallel_pins_oe_n(dev_oe_n),
    .o_low_end_serial_out(q0), .o_high_end_serial_out(q7), .o_capture_ready(cap_rdy), .i_awvalid(aw_v),
    .o_awready(aw_r), .i_awaddr(aw_a), .i_wvalid(w_v), .o_wready(w_r), .i_wdata(w_d), .i_wstrb(w_s),
    .o_bvalid(b_v), .i_bready(b_rdy), .o_bresp(b_resp), .i_arvalid(ar_v), .o_arready(ar_r), .i_araddr(ar_a),
    .o_rvalid(r_v), .i_rready(r_rdy), .o_rdata(r_d), .o_rresp(r_resp));
  shared_bus_partner bus (.i_clk(i_clk), .i_dev_data(dev_q), .i_dev_oe_n(dev_oe_n), .i_drive(drive),
    .i_drive_data(ld), .o_wire(pin_wire));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  function automatic logic [7:0] next_state(logic [7:0] s, logic c, logic [1:0] m, logic r, l, logic [7:0] p);
    if (!c) return 8'h00;
    case (m)
      2'b01: return {s[6:0], r};
      2'b10: return {l, s[7:1]};
      2'b11: return p;
      default: return s;
    endcase
  endfunction

  function automatic logic [31:0] status_word(logic [7:0] s, int n, logic o);
    status_t w;
    w = '0;
    w.state = s;
    w.fill = 8'(n);
    w.empty = (n == 0);
    w.full = (n == FIFO_DEPTH);
    w.overflow = o;
    return 32'(w);
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] want);
    checks_done++;
    if (got !== want) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 8000) begin
      errors++;
      report_and_stop();
    end
  end

  // One shift clock: inputs after the edge, oe_n checked at once, result checked after the next edge
  task automatic step(input logic c, input logic [1:0] m, input logic r, l, a, b, input logic [7:0] p);
    {clr_n, sel_hi, sel_lo, rsi, lsi, oea_n, oeb_n, drive, ld} <= {c, m, r, l, a, b, m == 2'b11, p};
    #1;
    check(32'(dev_oe_n), (!a && !b && m != 2'b11) ? 32'h0 : 32'hFF);
    @(posedge i_clk);
    exp_st = next_state(exp_st, c, m, r, l, p);
    if (cap_en && (!c || m != 2'b00)) begin
      if (lvl == FIFO_DEPTH) ovf = 1'b1;
      else begin
        snaps.push_back(exp_st);
        lvl++;
      end
    end
    #1;
    check({q7, q0, dev_q}, {exp_st[7], exp_st[0], exp_st});
    check(32'(cap_rdy), 32'(lvl != FIFO_DEPTH));
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic pa, pw, b;
    {aw_a, w_d, w_s, aw_v, w_v, b_rdy} <= {a, d, 4'hF, 3'b111};
    b = 1'b0;
    while (!b) begin
      @(negedge i_clk);
      pa = aw_v && aw_r;
      pw = w_v && w_r;
      b = b_v;
      r = b_resp;
      @(posedge i_clk);
      if (pa) aw_v <= 1'b0;
      if (pw) w_v <= 1'b0;
      if (b) b_rdy <= 1'b0;
    end
    // Let an edge pass so a following call never reassigns bready in the same time step
    @(posedge i_clk);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic pa, b;
    {ar_a, ar_v, r_rdy} <= {a, 2'b11};
    b = 1'b0;
    while (!b) begin
      @(negedge i_clk);
      pa = ar_v && ar_r;
      b = r_v;
      d = r_d;
      r = r_resp;
      @(posedge i_clk);
      if (pa) ar_v <= 1'b0;
      if (b) r_rdy <= 1'b0;
    end
    // Let an edge pass so back-to-back reads never reassign rready in the same time step
    @(posedge i_clk);
  endtask

  initial begin
    void'($urandom(32'h9e51));
    i_rst_n = 1'b0;
    {clr_n, sel_hi, sel_lo, rsi, lsi, oea_n, oeb_n, drive, ld} = 16'h8000;
    {aw_v, w_v, b_rdy, ar_v, r_rdy, aw_a, ar_a, w_d, w_s} = '0;
    {exp_st, lvl, ovf, cap_en, errors, checks_done, cycles} = '0;
    repeat (5) @(posedge i_clk);
    i_rst_n <= 1'b1;
    axi_read(CTRL_OFFSET, rd, rr);
    check(rd, 32'h0);
    axi_read(STATUS_OFFSET, rd, rr);
    check(rd, status_word(8'h00, 0, 1'b0));
    repeat (300) step(($urandom % 8) != 0, 2'($urandom), 1'($urandom), 1'($urandom), ($urandom % 4) == 0,
                      ($urandom % 4) == 0, 8'($urandom));
    step(1'b0, 2'b11, 1'b1, 1'b1, 1'b0, 1'b0, 8'hA5);
    step(1'b1, 2'b11, 1'b0, 1'b0, 1'b0, 1'b0, 8'h5A);
    step(1'b1, 2'b11, 1'b0, 1'b0, 1'b1, 1'b0, 8'hC3);
    step(1'b1, 2'b00, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    axi_write(CTRL_OFFSET, 32'h1, rr);
    check(32'(rr), 32'(RESP_OKAY));
    cap_en = 1'b1;
    // Overrun the FIFO so that the overflow path and the full flag are both reached
    repeat (FIFO_DEPTH + 8) step(1'b1, 2'b01, 1'($urandom), 1'b0, 1'($urandom), 1'b0, 8'h00);
    step(1'b1, 2'b00, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    axi_read(STATUS_OFFSET, rd, rr);
    check(rd, status_word(exp_st, lvl, ovf));
    repeat (FIFO_DEPTH) begin
      axi_read(CAPTURE_OFFSET, rd, rr);
      check(rd, {23'h0, 1'b1, snaps.pop_front()});
      lvl--;
    end
    axi_read(CAPTURE_OFFSET, rd, rr);
    check(rd & 32'h100, 32'h0);
    axi_write(STATUS_OFFSET, 32'h40000, rr);
    ovf = 1'b0;
    axi_read(STATUS_OFFSET, rd, rr);
    check(rd, status_word(exp_st, 0, 1'b0));
    axi_write(CAPTURE_OFFSET, 32'h0, rr);
    check(32'(rr), 32'(RESP_SLVERR));
    axi_read(8'h10, rd, rr);
    check({rr, rd[29:0]}, {RESP_SLVERR, 30'h0});
    report_and_stop();
  end
endmodule
